// ### core/caf_alu.sv
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - negative flag follows result sign bit on affecting ops
// - overflow flag reports two's complement wrap on arithmetic ops
// - zero flag clears on non-zero result, stays set otherwise on add and subtract
// - carry flag reports carry out of result msb, or the bit shifted out on shifts
// - on subtraction carry and half carry act as borrow complements
// - priority level bits ignore writes while nesting disable is one
// - priority msb plus three status bits form a four-bit level
// - user interrupts blocked while priority msb is one
// - program space window output follows window enable bit
// - unused control word bits read as zero
// - sixteen-bit add, subtract, shift and logic, two's complement
// - byte or word width taken from the command
// - operand A and add, subtract, logic and shift results routed to register array or memory
// - sixteen-bit divisor division assisted by a restoring divider
// - one seventeen-by-seventeen array forms all products
// - signed, unsigned, mixed, five-bit literal and eight-bit products
// - half carry from bit 3 for bytes, bit 7 for words
// - status bits seven to five hold low priority level
module caf_alu (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [15:0] memRdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] memWdata,
  output logic memWrite,
  output logic [3:0] cpuLevel,
  output logic userIrqBlock,
  output logic progWindowOn
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [15:0] flags, next_flags, ctrl, next_ctrl, opA, next_opA, opB, next_opB;
  logic [15:0] resLo, next_resLo, resHi, next_resHi, quo, next_quo;
  logic nestDis, next_nestDis;
  logic [8:0] cmd, next_cmd;
  caf_pkg::caf_state_t state, next_state;
  logic [4:0] divCnt, next_divCnt;
  logic [16:0] rem, next_rem;
  logic [31:0] next_prdata;
  logic next_ready, next_err, next_memWrite, next_block, next_window;
  logic [15:0] next_memWdata;
  logic [3:0] next_level;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [16:0] ext17(input logic [15:0] v, input logic sgn);
    ext17 = {sgn & v[15], v};
  endfunction
  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == caf_pkg::FLAGS_OFS) || (a == caf_pkg::CTRL_OFS) ||
      (a == caf_pkg::OPA_OFS) || (a == caf_pkg::OPB_OFS) ||
      (a == caf_pkg::CMD_OFS) || (a == caf_pkg::RESLO_OFS) ||
      (a == caf_pkg::RESHI_OFS) || (a == caf_pkg::NEST_OFS);
  endfunction
  // ----------------------------------------
  // datapath
  // ----------------------------------------
  logic [16:0] mulA, mulB, sum, trial;
  logic [33:0] prod;
  logic [15:0] srcA, aIn, bIn, res;
  logic byteOp, cOut, hc, ovf, arith, logicOp;
  caf_pkg::caf_op_t op;
  always_comb
  begin
    op = caf_pkg::caf_op_t'(cmd[caf_pkg::CMD_OP_LO +: 4]);
    byteOp = cmd[caf_pkg::CMD_BYTE_BIT];
    srcA = cmd[caf_pkg::CMD_SRC_BIT] ? memRdata : opA;
    aIn = byteOp ? {8'h00, srcA[7:0]} : srcA;
    bIn = byteOp ? {8'h00, opB[7:0]} : opB;
    // single array for every product size and sign mix
    mulA = (op == caf_pkg::OP_MUL8) ? {9'h000, srcA[7:0]} :
      ext17(aIn, cmd[caf_pkg::CMD_SA_BIT] & ~byteOp);
    case (op)
      caf_pkg::OP_MULLIT: mulB = {12'h000, opB[4:0]};
      caf_pkg::OP_MUL8: mulB = {9'h000, opB[7:0]};
      default: mulB = ext17(opB, cmd[caf_pkg::CMD_SB_BIT]);
    endcase
    prod = 34'($signed(mulA) * $signed(mulB));
    sum = 17'h00000;
    res = 16'h0000;
    cOut = 1'b0;
    hc = 1'b0;
    ovf = 1'b0;
    arith = 1'b0;
    logicOp = 1'b0;
    case (op)
      caf_pkg::OP_ADD:
      begin
        sum = {1'b0, aIn} + {1'b0, bIn};
        arith = 1'b1;
      end
      caf_pkg::OP_SUB:
      begin
        // borrow is the inverted carry of a + ~b + 1
        sum = {1'b0, aIn} + {1'b0, byteOp ? {8'h00, ~bIn[7:0]} : ~bIn} + 17'h00001;
        arith = 1'b1;
      end
      caf_pkg::OP_AND: begin res = aIn & bIn; logicOp = 1'b1; end
      caf_pkg::OP_OR: begin res = aIn | bIn; logicOp = 1'b1; end
      caf_pkg::OP_XOR: begin res = aIn ^ bIn; logicOp = 1'b1; end
      caf_pkg::OP_SHL:
      begin
        res = aIn << 1;
        cOut = byteOp ? aIn[7] : aIn[15];
        logicOp = 1'b1;
      end
      caf_pkg::OP_SHR:
      begin
        res = aIn >> 1;
        cOut = aIn[0];
        logicOp = 1'b1;
      end
      caf_pkg::OP_ASR:
      begin
        res = byteOp ? {8'h00, aIn[7], aIn[7:1]} : {aIn[15], aIn[15:1]};
        cOut = aIn[0];
        logicOp = 1'b1;
      end
      default: res = 16'h0000;
    endcase
    if (arith)
    begin
      res = sum[15:0];
      cOut = byteOp ? sum[8] : sum[16];
      // carry out of the 4th or 8th low-order bit
      hc = byteOp ? (aIn[4] ^ bIn[4] ^ (op == caf_pkg::OP_SUB) ^ sum[4])
                  : (aIn[8] ^ bIn[8] ^ (op == caf_pkg::OP_SUB) ^ sum[8]);
      if (byteOp)
        ovf = (aIn[7] ^ res[7]) & ~(aIn[7] ^ bIn[7] ^ (op == caf_pkg::OP_SUB));
      else
        ovf = (aIn[15] ^ res[15]) & ~(aIn[15] ^ bIn[15] ^ (op == caf_pkg::OP_SUB));
    end
    if (byteOp)
      res = {8'h00, res[7:0]};
    trial = {rem[15:0], quo[15]} - {1'b0, opB};
  end
  // ----------------------------------------
  // register and sequencing next state
  // ----------------------------------------
  logic wrEn, rdEn;
  logic [15:0] wdat, fl;
  always_comb
  begin
    wrEn = psel & penable & pwrite & ~pready;
    rdEn = psel & penable & ~pwrite & ~pready;
    wdat = pwdata[15:0];
    next_flags = flags;
    next_ctrl = ctrl;
    next_opA = opA;
    next_opB = opB;
    next_resLo = resLo;
    next_resHi = resHi;
    next_nestDis = nestDis;
    next_cmd = cmd;
    next_state = state;
    next_divCnt = divCnt;
    next_rem = rem;
    next_quo = quo;
    next_prdata = prdata;
    next_ready = 1'b0;
    next_err = 1'b0;
    next_memWdata = memWdata;
    next_memWrite = 1'b0;
    fl = flags;
    // bus waits while a command finishes, so reads never see a stale result
    if (psel & penable & ~pready & (state == caf_pkg::ST_IDLE))
    begin
      next_ready = 1'b1;
      next_err = ~isMapped(paddr);
    end
    if (wrEn && state == caf_pkg::ST_IDLE)
    begin
      case (paddr)
        caf_pkg::FLAGS_OFS:
        begin
          fl = wdat & caf_pkg::FLAGS_WMASK;
          if (nestDis)
            fl[caf_pkg::IPL_LO +: 3] = flags[caf_pkg::IPL_LO +: 3];
          next_flags = fl;
        end
        caf_pkg::CTRL_OFS: next_ctrl = wdat & caf_pkg::CTRL_WMASK;
        caf_pkg::OPA_OFS: next_opA = wdat;
        caf_pkg::OPB_OFS: next_opB = wdat;
        caf_pkg::NEST_OFS: next_nestDis = wdat[0];
        caf_pkg::CMD_OFS:
        begin
          next_cmd = wdat[8:0];
          next_state = caf_pkg::ST_DONE;
          if (wdat[3:0] == caf_pkg::OP_DIV)
          begin
            next_state = caf_pkg::ST_DIV;
            next_divCnt = 5'(caf_pkg::DIV_STEPS);
            next_rem = 17'h00000;
            next_quo = opA;
          end
        end
        default: next_flags = flags;
      endcase
    end
    if (rdEn && state == caf_pkg::ST_IDLE)
    begin
      case (paddr)
        caf_pkg::FLAGS_OFS: next_prdata = {16'h0000, flags};
        caf_pkg::CTRL_OFS: next_prdata = {16'h0000, ctrl};
        caf_pkg::OPA_OFS: next_prdata = {16'h0000, opA};
        caf_pkg::OPB_OFS: next_prdata = {16'h0000, opB};
        caf_pkg::CMD_OFS: next_prdata = {23'h000000, cmd};
        caf_pkg::RESLO_OFS: next_prdata = {16'h0000, resLo};
        caf_pkg::RESHI_OFS: next_prdata = {16'h0000, resHi};
        caf_pkg::NEST_OFS: next_prdata = {31'h00000000, nestDis};
        default: next_prdata = 32'h00000000;
      endcase
    end
    case (state)
      caf_pkg::ST_DIV:
      begin
        // one restoring step per clock, unsigned
        next_quo = {quo[14:0], ~trial[16]};
        next_rem = trial[16] ? {rem[15:0], quo[15]} : trial;
        next_divCnt = divCnt - 5'h01;
        if (divCnt == 5'h01)
          next_state = caf_pkg::ST_DONE;
      end
      caf_pkg::ST_DONE:
      begin
        next_state = caf_pkg::ST_IDLE;
        fl = flags;
        if (op == caf_pkg::OP_DIV)
        begin
          next_resLo = quo;
          next_resHi = rem[15:0];
          fl[caf_pkg::Z_BIT] = (quo == 16'h0000);
        end
        else if (op == caf_pkg::OP_MUL || op == caf_pkg::OP_MULLIT || op == caf_pkg::OP_MUL8)
        begin
          next_resLo = prod[15:0];
          next_resHi = prod[31:16];
        end
        else
        begin
          next_resLo = res;
          next_resHi = 16'h0000;
          if (cmd[caf_pkg::CMD_DST_BIT])
          begin
            next_memWdata = res;
            next_memWrite = 1'b1;
          end
          else
            next_opA = res;
          fl[caf_pkg::N_BIT] = byteOp ? res[7] : res[15];
          if (res != 16'h0000)
            fl[caf_pkg::Z_BIT] = 1'b0;
          else if (op != caf_pkg::OP_ADD && op != caf_pkg::OP_SUB)
            fl[caf_pkg::Z_BIT] = 1'b1;
          if (arith | (logicOp & (op >= caf_pkg::OP_SHL)))
            fl[caf_pkg::C_BIT] = cOut;
          if (arith)
          begin
            fl[caf_pkg::OV_BIT] = ovf;
            fl[caf_pkg::DC_BIT] = hc;
          end
        end
        next_flags = fl;
      end
      default: next_state = next_state;
    endcase
    next_level = {ctrl[caf_pkg::IPLMSB_BIT], flags[caf_pkg::IPL_LO +: 3]};
    next_block = ctrl[caf_pkg::IPLMSB_BIT] |
      (flags[caf_pkg::IPL_LO +: 3] == caf_pkg::IPL_TOP);
    next_window = ctrl[caf_pkg::PSV_BIT];
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      flags <= caf_pkg::FLAGS_RST;
      ctrl <= caf_pkg::CTRL_RST;
      opA <= 16'h0000;
      opB <= 16'h0000;
      resLo <= 16'h0000;
      resHi <= 16'h0000;
      nestDis <= 1'b0;
      cmd <= 9'h000;
      state <= caf_pkg::ST_IDLE;
      divCnt <= 5'h00;
      rem <= 17'h00000;
      quo <= 16'h0000;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      memWdata <= 16'h0000;
      memWrite <= 1'b0;
      cpuLevel <= 4'h0;
      userIrqBlock <= 1'b0;
      progWindowOn <= 1'b0;
    end
    else
    begin
      flags <= next_flags;
      ctrl <= next_ctrl;
      opA <= next_opA;
      opB <= next_opB;
      resLo <= next_resLo;
      resHi <= next_resHi;
      nestDis <= next_nestDis;
      cmd <= next_cmd;
      state <= next_state;
      divCnt <= next_divCnt;
      rem <= next_rem;
      quo <= next_quo;
      prdata <= next_prdata;
      pready <= next_ready;
      pslverr <= next_err;
      memWdata <= next_memWdata;
      memWrite <= next_memWrite;
      cpuLevel <= next_level;
      userIrqBlock <= next_block;
      progWindowOn <= next_window;
    end
  end
endmodule
`default_nettype wire

// ### core/caf_pkg.sv
package caf_pkg;
  // register offsets (byte addresses on the apb side)
  localparam logic [11:0] FLAGS_OFS = 12'h000;
  localparam logic [11:0] CTRL_OFS = 12'h004;
  localparam logic [11:0] OPA_OFS = 12'h008;
  localparam logic [11:0] OPB_OFS = 12'h00C;
  localparam logic [11:0] CMD_OFS = 12'h010;
  localparam logic [11:0] RESLO_OFS = 12'h014;
  localparam logic [11:0] RESHI_OFS = 12'h018;
  localparam logic [11:0] NEST_OFS = 12'h01C;
  // flag word field positions
  localparam int C_BIT = 0;
  localparam int Z_BIT = 1;
  localparam int OV_BIT = 2;
  localparam int N_BIT = 3;
  localparam int DC_BIT = 8;
  localparam int IPL_LO = 5;
  // control word field positions
  localparam int PSV_BIT = 2;
  localparam int IPLMSB_BIT = 3;
  // command field positions
  localparam int CMD_OP_LO = 0;
  localparam int CMD_BYTE_BIT = 4;
  localparam int CMD_DST_BIT = 5;
  localparam int CMD_SRC_BIT = 6;
  localparam int CMD_SA_BIT = 7;
  localparam int CMD_SB_BIT = 8;
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] FLAGS_WMASK = 16'h01EF;
  localparam logic [15:0] CTRL_WMASK = 16'h000C;
  localparam logic [2:0] IPL_TOP = 3'h7;
  localparam int DIV_STEPS = 16;
  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_SUB = 4'h1,
    OP_AND = 4'h2,
    OP_OR = 4'h3,
    OP_XOR = 4'h4,
    OP_SHL = 4'h5,
    OP_SHR = 4'h6,
    OP_ASR = 4'h7,
    OP_MUL = 4'h8,
    OP_MULLIT = 4'h9,
    OP_MUL8 = 4'hA,
    OP_DIV = 4'hB
  } caf_op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV = 2'b01,
    ST_DONE = 2'b10
  } caf_state_t;
endpackage

// ### verif/caf_alu_sva.sv
`timescale 1ns/1ps
`default_nettype none
module caf_alu_sva (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [15:0] memRdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] memWdata,
  input wire logic memWrite,
  input wire logic [3:0] cpuLevel,
  input wire logic userIrqBlock,
  input wire logic progWindowOn
);
  // ----
  // expected register copies
  // ----
  logic nestOn, wrDone;
  logic [1:0] ctlExp;
  logic [2:0] iplExp;
  assign wrDone = psel && penable && pwrite && pready;
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      nestOn <= 1'b0;
      ctlExp <= 2'h0;
      iplExp <= 3'h0;
    end
    else if (wrDone)
    begin
      if (paddr == caf_pkg::NEST_OFS)
        nestOn <= pwdata[0];
      if (paddr == caf_pkg::CTRL_OFS)
        ctlExp <= pwdata[3:2];
      if (paddr == caf_pkg::FLAGS_OFS && !nestOn)
        iplExp <= pwdata[7:5];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_wr(logic [11:0] ad);
    wrDone && paddr == ad;
  endsequence
  sequence s_memCmd;
    wrDone && paddr == caf_pkg::CMD_OFS && pwdata[5] && !pwdata[3];
  endsequence
  property p_ctl_rd;
    pready && !pwrite && paddr == caf_pkg::CTRL_OFS |-> (prdata & 32'hFFFFFFF3) == 32'h0;
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control reserved bits set");
  property p_irq;
    userIrqBlock == (cpuLevel[3] || cpuLevel[2:0] == 3'h7);
  endproperty
  a_irq: assert property (p_irq) else $error("irq block mismatch");
  property p_ipl;
    s_wr(caf_pkg::FLAGS_OFS) |-> ##2 cpuLevel[2:0] == iplExp;
  endproperty
  a_ipl: assert property (p_ipl) else $error("level bits mismatch");
  property p_msb;
    s_wr(caf_pkg::CTRL_OFS) |-> ##2 cpuLevel[3] == ctlExp[1];
  endproperty
  a_msb: assert property (p_msb) else $error("level msb mismatch");
  property p_psv;
    s_wr(caf_pkg::CTRL_OFS) |-> ##2 progWindowOn == ctlExp[0];
  endproperty
  a_psv: assert property (p_psv) else $error("window enable mismatch");
  property p_memw;
    s_memCmd |=> memWrite ##1 !memWrite;
  endproperty
  a_memw: assert property (p_memw) else $error("memory write pulse wrong");
  property p_rdy;
    pready |=> !pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready longer than one cycle");
  property p_unm;
    pready && paddr >= 12'h020 |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped access not refused");
endmodule
bind caf_alu caf_alu_sva u_caf_alu_sva (.clock, .nrst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .memRdata, .prdata, .pready, .pslverr, .memWdata, .memWrite, .cpuLevel,
  .userIrqBlock, .progWindowOn);
`default_nettype wire

// ### verif/cpu_alu_status_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_alu_status_flags_tb;
  logic clock = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rnd = 32'h85084320;
  logic [15:0] memRdata = 16'h0000;
  logic [31:0] prdata, rd, x, y, p;
  logic [15:0] memWdata, memCap, a, b, fw;
  logic [3:0] cpuLevel, mop;
  logic [4:0] c;
  logic pready, pslverr, memWrite, userIrqBlock, progWindowOn, err;
  int miscompares = 0, checks_done = 0, cycles = 0;
  logic [15:0] ca [4] = '{16'h7FFF, 16'hFFFF, 16'h0000, 16'h0080};
  logic [4:0] cc [4] = '{5'h00, 5'h00, 5'h01, 5'h11};
  caf_alu u_caf_alu (.clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .memRdata,
    .prdata, .pready, .pslverr, .memWdata, .memWrite, .cpuLevel, .userIrqBlock, .progWindowOn);
  // ----
  // bus tasks and expectations
  // ----
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    checks_done++;
    if ((got & m) !== (exp & m))
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got & m, exp & m);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] ad, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, ad, 32'h0);
    chk(rd, e, m);
  endtask
  task automatic run(input logic [31:0] cm);
    apb(1'b1, caf_pkg::FLAGS_OFS, {16'h0, fw});
    apb(1'b1, caf_pkg::OPA_OFS, {16'h0, a});
    apb(1'b1, caf_pkg::OPB_OFS, {16'h0, b});
    apb(1'b1, caf_pkg::CMD_OFS, cm);
  endtask
  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction
  function automatic logic [31:0] exp_alu(logic [4:0] k, logic [15:0] u, logic [15:0] v,
    logic [15:0] f);
    logic [16:0] s;
    logic [15:0] w, r;
    w = k[0] ? ~v : v;
    if (k[3:1] == 3'h0)
    begin
      s = k[4] ? u[7:0] + w[7:0] + k[0] : u + w + k[0];
      f[8] = k[4] ? (u[3:0] + w[3:0] + k[0]) > 15 : (u[7:0] + w[7:0] + k[0]) > 255;
      f[2] = k[4] ? (u[7] == w[7]) && (s[7] != u[7]) : (u[15] == w[15]) && (s[15] != u[15]);
      f[3] = k[4] ? s[7] : s[15];
      f[0] = k[4] ? s[8] : s[16];
      r = k[4] ? {8'h00, s[7:0]} : s[15:0];
      if (r != 16'h0)
        f[1] = 1'b0;
    end
    else
    begin
      if (k[4])
        u = u & 16'h00FF;
      case (k[2:0])
        3'h2: r = u & v;
        3'h3: r = u | v;
        3'h4: r = u ^ v;
        3'h5: r = {u[14:0], 1'b0};
        3'h6: r = {1'b0, u[15:1]};
        default: r = k[4] ? {8'h00, u[7], u[7:1]} : {u[15], u[15:1]};
      endcase
      if (k[4])
        r = r & 16'h00FF;
      if (k[2:0] > 3'h4)
        f[0] = (k[2:0] == 3'h5) ? (k[4] ? u[7] : u[15]) : u[0];
      f[3] = k[4] ? r[7] : r[15];
      f[1] = (r == 16'h0);
    end
    return {f, r};
  endfunction
  function automatic logic [31:0] exp_mul(logic [3:0] o, logic sa, logic sb, logic [15:0] u,
    logic [15:0] v);
    logic signed [16:0] m, n;
    logic signed [33:0] q;
    m = (o == 4'hA) ? {9'h000, u[7:0]} : {sa & u[15], u};
    n = (o == 4'hA) ? {9'h000, v[7:0]} : (o == 4'h9) ? {12'h000, v[4:0]} : {sb & v[15], v};
    q = m * n;
    return q[31:0];
  endfunction
  always #50 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (memWrite === 1'b1)
      memCap <= memWdata;
    if (cycles == 20000)
    begin
      miscompares++;
      close_out();
    end
  end
  initial
  begin
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 64; i++)
    begin
      x = xs();
      y = xs();
      c = (i < 4) ? cc[i] : {x[3], 1'b0, x[2:0]};
      a = (i < 4) ? ca[i] : x[31:16];
      b = (i < 4) ? 16'h0001 : y[15:0];
      fw = (i < 4) ? 16'h0002 : y[31:16] & caf_pkg::FLAGS_WMASK;
      run({27'h0, c});
      p = exp_alu(c, a, b, fw);
      rdc(caf_pkg::OPA_OFS, p & 32'hFFFF, 32'hFFFF);
      rdc(caf_pkg::FLAGS_OFS, p >> 16, 32'hFFFFFFFF);
    end
    for (int i = 0; i < 12; i++)
    begin
      x = xs();
      y = xs();
      mop = (i % 3 == 0) ? 4'h8 : (i % 3 == 1) ? 4'h9 : 4'hA;
      a = (i < 3) ? 16'hFFFF : x[31:16];
      b = (i < 3) ? 16'hFFFF : y[15:0];
      fw = y[31:16] & caf_pkg::FLAGS_WMASK;
      run({23'h0, x[1], x[0], 3'h0, mop});
      p = exp_mul(mop, x[0], x[1], a, b);
      rdc(caf_pkg::RESLO_OFS, p, 32'hFFFF);
      rdc(caf_pkg::RESHI_OFS, p >> 16, 32'hFFFF);
      rdc(caf_pkg::FLAGS_OFS, {16'h0, fw}, 32'hFFFFFFFF);
    end
    for (int i = 0; i < 6; i++)
    begin
      x = xs();
      a = x[31:16];
      b = (i == 0) ? 16'h0000 : (i == 1) ? 16'h0001 : x[15:0] >> i;
      fw = x[15:0] & caf_pkg::FLAGS_WMASK;
      run(32'h0000000B);
      rdc(caf_pkg::RESLO_OFS, (b == 16'h0) ? 32'hFFFF : a / b, 32'hFFFF);
      if (b != 16'h0)
        rdc(caf_pkg::RESHI_OFS, a % b, 32'hFFFF);
      rdc(caf_pkg::FLAGS_OFS, {16'h0, fw}, 32'hFFFFFFFD);
    end
    x = xs();
    @(posedge clock);
    memRdata <= x[15:0];
    a = 16'h0000;
    b = x[31:16];
    fw = 16'h0000;
    run(32'h00000060);
    repeat (3) @(posedge clock);
    chk({16'h0, memCap}, {16'h0, x[15:0] + x[31:16]}, 32'hFFFF);
    apb(1'b1, caf_pkg::CTRL_OFS, 32'hFFFFFFFF);
    rdc(caf_pkg::CTRL_OFS, 32'h0000000C, 32'hFFFFFFFF);
    chk({29'h0, progWindowOn, userIrqBlock, cpuLevel[3]}, 32'h7, 32'h7);
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    chk({26'h0, cpuLevel, userIrqBlock, progWindowOn}, 32'h0, 32'h3F);
    rdc(caf_pkg::CTRL_OFS, 32'h0, 32'hFFFFFFFF);
    apb(1'b1, caf_pkg::CTRL_OFS, 32'h0);
    apb(1'b1, caf_pkg::FLAGS_OFS, 32'hE0);
    apb(1'b1, caf_pkg::NEST_OFS, 32'h1);
    apb(1'b1, caf_pkg::FLAGS_OFS, 32'h0);
    rdc(caf_pkg::FLAGS_OFS, 32'hE0, 32'hE0);
    chk({26'h0, cpuLevel, userIrqBlock, progWindowOn}, 32'h1E, 32'h3F);
    apb(1'b1, caf_pkg::NEST_OFS, 32'h0);
    apb(1'b1, caf_pkg::FLAGS_OFS, 32'h0);
    rdc(caf_pkg::FLAGS_OFS, 32'h0, 32'hE0);
    rdc(12'h020, 32'h0, 32'hFFFFFFFF);
    chk({31'h0, err}, 32'h1, 32'h1);
    close_out();
  end
endmodule
`default_nettype wire
